// ### src/sps_regs.svh
// register offsets, field positions, reset values and timing counts of the serial port
// assumes a 32-bit apb bus, one aligned word per register
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// byte offsets
`define SPS_OFF_FMT      8'h00
`define SPS_OFF_TXH      8'h04
`define SPS_OFF_RXH      8'h08
`define SPS_OFF_CTRL     8'h0C
`define SPS_OFF_STATUS   8'h10
`define SPS_OFF_MASK     8'h14

// reset values
`define SPS_RST_FMT      8'h00
`define SPS_RST_TXH      8'hFF
`define SPS_RST_RXH      8'h00
`define SPS_RST_CTRL     8'h00
`define SPS_RST_MASK     8'h00

// control bits
`define SPS_CTRL_TXEN    0
`define SPS_CTRL_RXEN    1
`define SPS_CTRL_MPE     2
`define SPS_CTRL_STBY    3
`define SPS_CTRL_MPBTX   4

// status bits: bit 0 and 6 are levels, bits 5..1 sticky
`define SPS_ST_HEMPTY    0
`define SPS_ST_RXFULL    1
`define SPS_ST_FRAME     2
`define SPS_ST_PARITY    3
`define SPS_ST_OVERRUN   4
`define SPS_ST_TXEND     5
`define SPS_ST_RXMPB     6
`define SPS_STICKY       8'h3E

// prescaled ticks per bit and the tick at which a bit is sampled
`define SPS_SUB_LAST     4'hF
`define SPS_SUB_SAMPLE   4'h7
`define SPS_SCK_RISE     4'h8

// prescaler limits for codes 01, 10, 11
`define SPS_DIV4_LAST    6'h03
`define SPS_DIV16_LAST   6'h0F
`define SPS_DIV64_LAST   6'h3F

`endif

// ### src/sps_pkg.sv
// types shared by the serial port files
// assumes sps_regs.svh for the numbers
package sps_pkg;

  // frame format mode register layout
  typedef struct packed {
    logic       sync;     // 1: clocked synchronous
    logic       chr;      // char_length_select, 1: seven bits
    logic       pe;       // parity_enable
    logic       odd;      // 1: odd parity
    logic       stop2;    // 1: two stop bits
    logic       mp;       // multiproc_format_select
    logic [1:0] cks;      // clock_select_hi, clock_select_lo
  } sps_fmt_t;

  // receiver states
  typedef enum logic [1:0] {
    SPS_RX_IDLE = 2'b01,
    SPS_RX_RUN  = 2'b10
  } sps_rx_st_t;

  // state of the whole port
  typedef struct packed {
    sps_fmt_t   fmt;
    logic [7:0] txh;
    logic [7:0] rxh;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] sts;
    logic       hempty;
    logic       rx_mpb;
    logic       tx_busy;
    logic [3:0] tx_sub;
    logic [3:0] tx_cnt;
    logic [11:0] tx_sh;
    logic       txd;
    logic       sck;
    sps_rx_st_t rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_cnt;
    logic [9:0] rx_sh;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
    logic       irq;
  } sps_state_t;

  // prescaler state
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } sps_baud_t;

endpackage : sps_pkg

// ### src/sps_baud_gen.sv
// baud prescaler: one-cycle tick at clock, /4, /16 or /64
// assumes one clock; code changes take effect at once, on the count in progress
`timescale 1ns/1ns
`default_nettype none
`include "sps_regs.svh"

module sps_baud_gen (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic [1:0] cks_i,
  input  wire logic       run_i,
  // tick out
  output logic            tick_o
);

  sps_pkg::sps_baud_t s_r;
  sps_pkg::sps_baud_t s_nxt;
  logic [5:0]         last;

  // divider: code 00 ticks every cycle
  always_comb
  begin
    s_nxt = s_r;
    if (cks_i == 2'h1)
      last = `SPS_DIV4_LAST;
    else if (cks_i == 2'h2)
      last = `SPS_DIV16_LAST;
    else if (cks_i == 2'h3)
      last = `SPS_DIV64_LAST;
    else
      last = 6'h00;
    s_nxt.tick = 1'b0;
    if (!run_i)
      s_nxt.cnt = 6'h00;
    else if (s_r.cnt >= last)
    begin
      s_nxt.cnt  = 6'h00;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = s_r.cnt + 6'h01;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_o = s_r.tick;

  a_div64_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tick_o && cks_i == 2'h3 && $stable(cks_i)) |=> !tick_o [*8])
    else $error("divide by 64 ticks too soon");

endmodule : sps_baud_gen
`default_nettype wire

// ### src/sps_top.sv
// serial port data path: shifters, holding registers, frame format mode, apb slave
// assumes apb3 master on mclk_i, rxd_i synchronous to mclk_i
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sps_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module sps_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial line
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             sck_o,
  output logic             sck_oe_o,
  // interrupt
  output logic             irq_o
);

  sps_pkg::sps_state_t s_r;
  sps_pkg::sps_state_t s_nxt;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        sync;
  logic        seven;
  logic        mp_on;
  logic        par_on;
  logic        xtra;
  logic [3:0]  dn;
  logic [3:0]  rlen;
  logic [7:0]  td;
  logic        txb;
  logic [11:0] fr;
  logic [3:0]  flen;
  logic [7:0]  rd8;
  logic        rxb;
  logic        tx_done;
  logic        tx_load;
  logic        rx_load;
  logic [7:0]  set;
  logic [7:0]  clr;

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler stops in standby so the bit timing restarts cleanly
  sps_baud_gen u_baud (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .cks_i  (s_r.fmt.cks),
    .run_i  (~s_r.ctrl[`SPS_CTRL_STBY]),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // format decode shared by both directions
  always_comb
  begin
    sync   = s_r.fmt.sync;
    seven  = ~sync & s_r.fmt.chr;
    mp_on  = ~sync & s_r.fmt.mp & s_r.ctrl[`SPS_CTRL_MPE];
    par_on = ~sync & s_r.fmt.pe & ~mp_on;
    xtra   = par_on | mp_on;
    dn     = seven ? 4'h7 : 4'h8;
    rlen   = dn + {3'h0, xtra} + 4'h1;
    td     = s_r.txh & {~seven, 7'h7F};
    // even parity makes total ones even, odd makes it odd
    txb    = mp_on ? s_r.ctrl[`SPS_CTRL_MPBTX] : ((^td) ^ s_r.fmt.odd);
  end

  // transmit frame image, lsb leaves first, unused tail stays idle high
  always_comb
  begin
    fr = 12'hFFF;
    if (sync)
    begin
      fr[7:0] = s_r.txh;
      flen    = 4'h8;
    end
    else
    begin
      fr[0] = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        if (4'(i) < dn)
          fr[i + 1] = td[i];
      end
      if (xtra)
        fr[dn + 4'h1] = txb;
      flen = rlen + 4'h1 + {3'h0, s_r.fmt.stop2};
    end
  end

  // received character, bit 7 forced low for seven-bit frames
  always_comb
  begin
    rd8 = s_r.rx_sh[7:0] & {~seven, 7'h7F};
    rxb = s_r.rx_sh[dn];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state of the whole port
  always_comb
  begin
    s_nxt   = s_r;
    acc     = psel_i & penable_i & s_r.pready;
    wr      = acc & pwrite_i;
    rd      = acc & ~pwrite_i;
    set     = 8'h00;
    clr     = 8'h00;
    tx_done = 1'b0;
    tx_load = 1'b0;
    rx_load = 1'b0;

    // apb: one wait state, read data prepared while pready rises
    s_nxt.pready = psel_i & penable_i & ~s_r.pready;
    if (s_nxt.pready)
    begin
      s_nxt.pslverr = 1'b0;
      if (paddr_i == `SPS_OFF_FMT)
        s_nxt.prdata = {24'h000000, s_r.fmt};
      else if (paddr_i == `SPS_OFF_TXH)
        s_nxt.prdata = {24'h000000, s_r.txh};
      else if (paddr_i == `SPS_OFF_RXH)
        s_nxt.prdata = {24'h000000, s_r.rxh};
      else if (paddr_i == `SPS_OFF_CTRL)
        s_nxt.prdata = {24'h000000, s_r.ctrl};
      else if (paddr_i == `SPS_OFF_STATUS)
        s_nxt.prdata = {24'h000000, 1'b0, s_r.rx_mpb, s_r.sts[5:1], s_r.hempty};
      else if (paddr_i == `SPS_OFF_MASK)
        s_nxt.prdata = {24'h000000, s_r.mask};
      else
      begin
        // shifters have no address, so they fall here too
        s_nxt.prdata  = 32'h00000000;
        s_nxt.pslverr = 1'b1;
      end
    end
    else
    begin
      s_nxt.prdata  = 32'h00000000;
      s_nxt.pslverr = 1'b0;
    end
    if (rd && paddr_i == `SPS_OFF_STATUS)
      clr = `SPS_STICKY;

    // transmit shifter
    if (s_r.tx_busy && tick)
    begin
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;
      if (sync && s_r.tx_sub == `SPS_SUB_SAMPLE)
        s_nxt.rx_sh[7:0] = {rxd_i, s_r.rx_sh[7:1]};
      if (s_r.tx_sub == `SPS_SUB_LAST)
      begin
        s_nxt.tx_sh  = {1'b1, s_r.tx_sh[11:1]};
        s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
        if (s_r.tx_cnt == 4'h1)
        begin
          tx_done       = 1'b1;
          s_nxt.tx_busy = 1'b0;
        end
      end
    end
    // sync receive rides on the transmit clock
    if (tx_done && sync && s_r.ctrl[`SPS_CTRL_RXEN])
    begin
      s_nxt.rxh = s_nxt.rx_sh[7:0];
      set[`SPS_ST_RXFULL]  = 1'b1;
      set[`SPS_ST_OVERRUN] = s_r.sts[`SPS_ST_RXFULL];
    end
    // no gap between characters when software refilled in time
    if ((~s_r.tx_busy | tx_done) && ~s_r.hempty && s_r.ctrl[`SPS_CTRL_TXEN])
    begin
      tx_load        = 1'b1;
      s_nxt.tx_busy  = 1'b1;
      s_nxt.tx_sh    = fr;
      s_nxt.tx_cnt   = flen;
      s_nxt.tx_sub   = 4'h0;
      s_nxt.hempty   = 1'b1;
    end
    else if (tx_done)
      set[`SPS_ST_TXEND] = 1'b1;

    // asynchronous receive shifter
    if (sync || !s_r.ctrl[`SPS_CTRL_RXEN])
      s_nxt.rx_st = sps_pkg::SPS_RX_IDLE;
    else
    begin
      case (s_r.rx_st)
        sps_pkg::SPS_RX_IDLE:
        begin
          // a low second stop bit lands here as a new start
          if (!rxd_i)
          begin
            s_nxt.rx_st  = sps_pkg::SPS_RX_RUN;
            s_nxt.rx_sub = 4'h0;
            s_nxt.rx_cnt = 4'h0;
          end
        end
        sps_pkg::SPS_RX_RUN:
        begin
          if (tick)
          begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
            if (s_r.rx_sub == `SPS_SUB_SAMPLE)
            begin
              if (s_r.rx_cnt == 4'h0)
              begin
                // high at mid start is a glitch, not a character
                if (rxd_i)
                  s_nxt.rx_st = sps_pkg::SPS_RX_IDLE;
                else
                  s_nxt.rx_cnt = 4'h1;
              end
              else if (s_r.rx_cnt == rlen)
              begin
                // first stop bit only; free the shifter now
                rx_load     = 1'b1;
                s_nxt.rx_st = sps_pkg::SPS_RX_IDLE;
                s_nxt.rxh   = rd8;
                s_nxt.rx_mpb = mp_on & rxb;
                set[`SPS_ST_RXFULL]  = 1'b1;
                set[`SPS_ST_OVERRUN] = s_r.sts[`SPS_ST_RXFULL];
                set[`SPS_ST_FRAME]   = ~rxd_i;
                set[`SPS_ST_PARITY]  = par_on & ((^rd8) ^ rxb ^ s_r.fmt.odd);
              end
              else
              begin
                s_nxt.rx_sh[s_r.rx_cnt - 4'h1] = rxd_i;
                s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
              end
            end
          end
        end
        default:
          s_nxt.rx_st = sps_pkg::SPS_RX_IDLE;
      endcase
    end

    // register writes; receive holding has no write path
    if (wr)
    begin
      if (paddr_i == `SPS_OFF_FMT)
        s_nxt.fmt = sps_pkg::sps_fmt_t'(pwdata_i[7:0]);
      else if (paddr_i == `SPS_OFF_TXH)
      begin
        s_nxt.txh    = pwdata_i[7:0];
        s_nxt.hempty = 1'b0;
      end
      else if (paddr_i == `SPS_OFF_CTRL)
        s_nxt.ctrl = pwdata_i[7:0];
      else if (paddr_i == `SPS_OFF_MASK)
        s_nxt.mask = pwdata_i[7:0];
    end

    // sticky status: an event in the clearing cycle survives
    s_nxt.sts = (s_r.sts & ~clr) | (set & `SPS_STICKY);

    // standby holds the data path in its reset values
    if (s_nxt.ctrl[`SPS_CTRL_STBY])
    begin
      s_nxt.fmt     = sps_pkg::sps_fmt_t'(`SPS_RST_FMT);
      s_nxt.txh     = `SPS_RST_TXH;
      s_nxt.rxh     = `SPS_RST_RXH;
      s_nxt.hempty  = 1'b1;
      s_nxt.tx_busy = 1'b0;
      s_nxt.rx_st   = sps_pkg::SPS_RX_IDLE;
    end

    // line outputs; sync clock low in the first half of each bit
    s_nxt.txd = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1;
    s_nxt.sck = ~(s_nxt.tx_busy & s_nxt.fmt.sync & (s_nxt.tx_sub < `SPS_SCK_RISE));
    s_nxt.irq = (|(s_nxt.sts & s_nxt.mask)) | (s_nxt.mask[`SPS_ST_HEMPTY] & s_nxt.hempty);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_r        <= '0;
      s_r.fmt    <= sps_pkg::sps_fmt_t'(`SPS_RST_FMT);
      s_r.txh    <= `SPS_RST_TXH;
      s_r.rxh    <= `SPS_RST_RXH;
      s_r.ctrl   <= `SPS_RST_CTRL;
      s_r.mask   <= `SPS_RST_MASK;
      s_r.hempty <= 1'b1;
      s_r.txd    <= 1'b1;
      s_r.sck    <= 1'b1;
      s_r.rx_st  <= sps_pkg::SPS_RX_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state flops
  assign prdata_o  = s_r.prdata;
  assign pready_o  = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign txd_o     = s_r.txd;
  assign sck_o     = s_r.sck;
  assign sck_oe_o  = s_r.fmt.sync;
  assign irq_o     = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_load_needs_data: assert property (tx_load |-> !s_r.hempty)
    else $error("shifter loaded from empty holding register");
  a_start_bit_out: assert property ((tx_load && !sync) |=> !txd_o [*8])
    else $error("async frame does not open with a start bit");
  a_rx_free_now: assert property (rx_load |=> s_r.rx_st == sps_pkg::SPS_RX_IDLE)
    else $error("receive shifter not freed after transfer");
  a_rx_moved: assert property (rx_load |=> s_r.rxh == $past(rd8) && s_r.sts[`SPS_ST_RXFULL])
    else $error("received character not moved to holding register");
  a_rxh_no_write: assert property ((wr && paddr_i == `SPS_OFF_RXH && !rx_load && !tx_done
    && !s_r.ctrl[`SPS_CTRL_STBY]) |=> $stable(s_r.rxh))
    else $error("receive holding changed by a write");
  a_standby_vals: assert property (s_r.ctrl[`SPS_CTRL_STBY] |-> s_r.rxh == 8'h00
    && s_r.txh == 8'hFF && s_r.fmt == 8'h00)
    else $error("standby values wrong");
  a_seven_msb: assert property ((rx_load && seven) |=> !s_r.rxh[7])
    else $error("seven-bit character has bit 7 set");
  a_frame_len: assert property ((tx_load && !sync) |-> flen == 4'h2 + (s_r.fmt.chr ? 4'h7 : 4'h8)
    + {3'h0, s_r.fmt.pe | (s_r.fmt.mp & s_r.ctrl[`SPS_CTRL_MPE])} + {3'h0, s_r.fmt.stop2})
    else $error("async frame length wrong");
  a_mp_gated: assert property (!s_r.ctrl[`SPS_CTRL_MPE] |-> !mp_on && (par_on == (!sync
    && s_r.fmt.pe)))
    else $error("multiprocessor format active without global enable");
  a_empty_clear: assert property ((wr && paddr_i == `SPS_OFF_TXH && !s_nxt.ctrl[`SPS_CTRL_STBY])
    |=> !s_r.hempty)
    else $error("empty flag not cleared by a write");
  a_apb_wait: assert property ((psel_i && penable_i && !s_r.pready) |=> pready_o ##1 !pready_o)
    else $error("apb answer not after one wait state");

  c_tx_back: cover property (tx_done && tx_load);
  c_rx_parity: cover property (rx_load && par_on);
  c_sync_rx: cover property (tx_done && sync && s_r.ctrl[`SPS_CTRL_RXEN]);

endmodule : sps_top
`default_nettype wire

// ### bench/sps_line_peer.sv
// line-side peer port: sends frames on rxd and captures frames from txd
// assumes the bench builds and judges frames; bit time is given in clocks
`timescale 1ns/1ns
`default_nettype none

module sps_line_peer (
  // clock
  input  wire logic mclk_i,
  // serial line
  input  wire logic txd_i,
  output logic      rxd_o
);
  // line rests at mark between frames
  initial rxd_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // send n bits lsb first, b clocks each; called just after a rising edge
  task automatic send(input logic [23:0] v, input int n, input int b);
    for (int j = 0; j < n; j++)
    begin
      rxd_o <= v[j];
      repeat (b) @(posedge mclk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  // catch n bits from the start edge; low is the length of the first run of ones, 0 on timeout
  // the start bit is not timed: its length depends on the prescaler phase at load
  task automatic recv(input int b, input int n, output logic [11:0] f, output int low);
    int i;
    int hi;
    f   = '1;
    low = 0;
    hi  = 0;
    i   = 0;
    while (txd_i !== 1'b0 && i < 20000)
    begin
      @(posedge mclk_i);
      i++;
    end
    if (i < 20000)
    begin
      for (i = 0; i < b * n; i++)
      begin
        @(posedge mclk_i);
        if (hi == 0 && txd_i === 1'b1)
          hi = i + 1;
        else if (hi != 0 && low == 0 && txd_i === 1'b0)
          low = i + 1 - hi;
        if (i % b == b / 2)
          f[i / b] = txd_i; // mid-bit sample
      end
    end
  endtask : recv
endmodule : sps_line_peer
`default_nettype wire

// ### bench/tb_serial_port_buffers_and_format.sv
// self-checking bench for the serial port: apb tasks, line peer, frame checks
// assumes sps_top with mclk_i at 50 MHz and the peer on the serial pins
`timescale 1ns/1ns
`default_nettype none
`include "sps_regs.svh"

module tb_serial_port_buffers_and_format;
  logic        mclk_i, rst_i, psel_i, penable_i, pwrite_i, rxd_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic        pready_o, pslverr_o, txd_o, sck_o, sck_oe_o, irq_o, perr, sk;
  logic [11:0] f, g, v, w;
  logic [7:0]  sv;
  int          errors, checks_done, low, n, m, k;
  logic [7:0]  tf[8] = '{8'h00, 8'h68, 8'h78, 8'h24, 8'h24, 8'h01, 8'h02, 8'h03};
  logic [7:0]  tc[8] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h17, 8'h03, 8'h03, 8'h03};
  logic [7:0]  td[8] = '{8'hA5, 8'hD5, 8'hD5, 8'h3B, 8'h3B, 8'hA5, 8'hA5, 8'hA5};
  int          tb_b[8] = '{16, 16, 16, 16, 16, 64, 256, 1024};

  sps_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .irq_o(irq_o));
  sps_line_peer u_peer (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // free-running 20 ns clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 50);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (i >= 50)
    begin
      errors++;
      final_report();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // read and compare the bits under m
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdat & m, e);
  endtask : rc

  // expected frame from the mode bits; returns bit count with start
  function automatic int mk(input logic [7:0] d, input logic [7:0] fm, input logic [7:0] ct,
                            output logic [11:0] fr);
    int nd;
    logic [7:0] u;
    nd = fm[6] ? 7 : 8;
    u  = fm[6] ? (d & 8'h7F) : d;
    fr = '1;
    fr[0] = 1'b0;
    for (int j = 0; j < nd; j++)
      fr[j + 1] = u[j];
    if (fm[2] && ct[2])
    begin
      fr[nd + 1] = ct[4];
      nd++;
    end
    else if (fm[5])
    begin
      fr[nd + 1] = (^u) ^ fm[4];
      nd++;
    end
    return nd + 2 + fm[3];
  endfunction : mk

  // transmit one character and judge the frame; d[0] is 1 so a run of ones follows the start bit
  task automatic txcase(input logic [7:0] fm, input logic [7:0] ct, input logic [7:0] d, input int b);
    wr(`SPS_OFF_FMT, fm);
    wr(`SPS_OFF_CTRL, ct);
    n = mk(d, fm, ct, v);
    fork
      u_peer.recv(b, n, f, low);
      wr(`SPS_OFF_TXH, d);
    join
    chk(f & (12'hFFF >> (12 - n)), v & (12'hFFF >> (12 - n)));
    k = 1;
    while (k < 11 && v[k] === 1'b1)
      k++;
    chk(low, b * (k - 1));
    if (low == 0)
      final_report();
  endtask : txcase

  // send a frame, flipping the parity bit if bad, then check holding and status
  task automatic rxcase(input logic [7:0] fm, input logic [7:0] d, input logic bad);
    wr(`SPS_OFF_FMT, fm);
    apb(1'b0, `SPS_OFF_STATUS, 8'h00);
    n = mk(d, fm, 8'h03, v);
    v[fm[6] ? 8 : 9] ^= bad;
    u_peer.send({12'hFFF, v}, n, 16);
    repeat (4) @(posedge mclk_i);
    chk(irq_o, 1'b0); // masked event keeps the line low
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, fm[6] ? (d & 8'h7F) : d);
    rc(`SPS_OFF_STATUS, 32'h0E, {bad, 3'b010});
  endtask : rxcase

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rc(`SPS_OFF_FMT, 32'hFFFFFFFF, 32'h00);
    rc(`SPS_OFF_TXH, 32'hFFFFFFFF, 32'hFF);
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, 32'h00);
    rc(`SPS_OFF_STATUS, 32'h01, 32'h01);
    rc(8'h18, 32'hFFFFFFFF, 32'h00);
    chk(perr, 1'b1);
    wr(`SPS_OFF_FMT, 8'h5A);
    rc(`SPS_OFF_FMT, 32'hFFFFFFFF, 32'h5A);
    for (int c = 0; c < 8; c++)
      txcase(tf[c], tc[c], td[c], tb_b[c]);
    // second character written while the first shifts
    wr(`SPS_OFF_FMT, 8'h00);
    n = mk(8'h5B, 8'h00, 8'h03, v);
    m = mk(8'hC3, 8'h00, 8'h03, w);
    fork
      begin
        u_peer.recv(16, 10, f, low);
        u_peer.recv(16, 10, g, k);
      end
      begin
        wr(`SPS_OFF_TXH, 8'h5B);
        wr(`SPS_OFF_TXH, 8'hC3);
      end
    join
    chk({g[9:0], f[9:0]}, {w[9:0], v[9:0]});
    repeat (64) @(posedge mclk_i);
    chk(txd_o, 1'b1);
    rc(`SPS_OFF_STATUS, 32'h21, 32'h21);
    // receive side
    rxcase(8'h00, 8'h3C, 1'b0);
    rxcase(8'h78, 8'hB1, 1'b0);
    rxcase(8'h78, 8'hB1, 1'b1);
    n = mk(8'h81, 8'h00, 8'h03, v);
    m = mk(8'h4E, 8'h00, 8'h03, w);
    wr(`SPS_OFF_FMT, 8'h08);
    u_peer.send({2'b11, w[9:0], v[9:0]}, 22, 16);
    repeat (4) @(posedge mclk_i);
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, 32'h4E);
    rc(`SPS_OFF_STATUS, 32'h06, 32'h02);
    wr(`SPS_OFF_RXH, 8'h77);
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, 32'h4E);
    // interrupt raised, cleared by status read, then raised again by the empty flag
    wr(`SPS_OFF_FMT, 8'h00);
    wr(`SPS_OFF_MASK, 8'h02);
    u_peer.send({12'hFFF, v}, 10, 16);
    repeat (4) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    apb(1'b0, `SPS_OFF_STATUS, 8'h00);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    wr(`SPS_OFF_MASK, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    wr(`SPS_OFF_MASK, 8'h00);
    // clocked synchronous send, bits caught at serial clock rise
    wr(`SPS_OFF_FMT, 8'h80);
    // the mode flop updates at the completing edge, so look one edge later
    @(posedge mclk_i);
    chk(sck_oe_o, 1'b1);
    sk = sck_o;
    k = 0;
    fork
      wr(`SPS_OFF_TXH, 8'h96);
      for (int i = 0; i < 600 && k < 8; i++)
      begin
        @(posedge mclk_i);
        if (sck_o === 1'b1 && sk === 1'b0)
        begin
          sv[k] = txd_o;
          k++;
        end
        sk = sck_o;
      end
    join
    chk(sv, 8'h96);
    if (k < 8)
      final_report();
    // receive rides on the serial clock; the idle-high line gives all ones
    repeat (16) @(posedge mclk_i);
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, 32'hFF);
    // standby returns the holding and mode registers to reset values
    wr(`SPS_OFF_CTRL, 8'h08);
    rc(`SPS_OFF_FMT, 32'hFFFFFFFF, 32'h00);
    rc(`SPS_OFF_TXH, 32'hFFFFFFFF, 32'hFF);
    rc(`SPS_OFF_RXH, 32'hFFFFFFFF, 32'h00);
    final_report();
  end
endmodule : tb_serial_port_buffers_and_format
`default_nettype wire
